// File: hdl/uart_intr_ctrl.v
// Interrupt ranking, queue control and modem control of a serial
// controller, reached over APB. Assumes one 10 MHz clock, and that
// receive and transmit queue activity is signalled through registers.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "uart_intr_ctrl_regs.vh"

// Functional notes
// R1 - Sources ranked: line status, receive data/timeout, tx empty, modem.
// R2 - Reading identification freezes the highest pending source.
// R3 - Ident bit 0 is 0 when pending; bits 2:1 name the source.
// R4 - Line errors post 0110; reading line status clears it.
// R5 - Data available or trigger level posts 0100; buffer read clears.
// R6 - Queue timeout after 4 idle character times posts 1100.
// R7 - Tx empty posts 0010; ident read or holding write clears.
// R8 - Modem change posts 0000; modem status read clears it.
// R9 - Ident bit 3 is zero in character mode, set on timeout.
// R10 - Ident bits 5:4 zero; bits 7:6 follow queue enable.
// R11 - Queue control is write-only sharing the ident address.
// R12 - Enable bit enables queues; writing zero empties both.
// R13 - Clear bits empty the chosen queue and self clear.
// R14 - Bit 3 selects ready pin mode 1 when enabled.
// R15 - Bits 7:6 select trigger level 1, 4, 8 or 14.
// R16 - Enable bits 3:0 gate four sources; bits 7:4 read zero.
// R17 - All enables clear inhibits ident and interrupt output.
// R18 - Modem control bits 3:0 drive active-low pins inverted.
// R19 - Loopback holds serial out at mark and forces pins high.
// R20 - In loopback, modem interrupts come from control bits.
// R21 - Writes to line and modem status bits raise interrupts.
// R22 - Software idles transmitter while changing loopback.
// R23 - Interrupt output high while any enabled source pends.
module uart_intr_ctrl #(
    parameter DEPTH        = 16,
    parameter TIMEOUT_CYC  = ((`CHAR_TIME_NS * `TIMEOUT_CHARS)
                              + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire        mclk,
    input  wire        rstn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        serialIn,
    input  wire        txShiftOut,
    input  wire        ctsN,
    input  wire        dsrN,
    input  wire        ringN,
    input  wire        carrierDetectN,
    output reg         serialOut,
    output reg         rxShiftIn,
    output reg         dtrN,
    output reg         rtsN,
    output reg         out1N,
    output reg         out2N,
    output reg         irqOut,
    output reg         rxReadyPin,
    output reg         txReadyPin
);

    localparam CW = 5;
    localparam TW = 23;

    reg  [3:0]    ienable_ff;
    reg  [4:0]    mctrl_ff;
    reg           fifoEn_ff;
    reg           pinMode_ff;
    reg  [1:0]    trig_ff;
    reg  [CW-1:0] rxCnt_ff;
    reg  [CW-1:0] txCnt_ff;
    reg  [5:0]    lstat_ff;
    reg  [3:0]    mstat_ff;
    reg           thre_ff;
    reg  [TW-1:0] tmo_ff;
    reg  [3:0]    frozen_ff;
    reg           freeze_ff;
    reg  [3:0]    modemS1_ff;
    reg  [3:0]    modemS2_ff;
    reg  [3:0]    modemPrev_ff;
    reg           sinS1_ff;
    reg           sinS2_ff;

    wire          acc   = psel & penable & pready;
    wire          wrAcc = acc & pwrite;
    wire          rdAcc = acc & ~pwrite;
    wire [7:0]    wd    = pwdata[7:0];
    wire          wrMc  = wrAcc & (paddr == `OFS_MCTRL);

    // Modem input levels, active high, from pins or loopback controls.
    // In loopback clear-to-send follows request-to-send and data-set-ready
    // follows terminal-ready; ring and carrier follow the two auxiliaries.
    wire [3:0] modemLvl = mctrl_ff[`MC_LOOP]
                        ? {mctrl_ff[3:2], mctrl_ff[0], mctrl_ff[1]}
                        : ~modemS2_ff; // R20

    // Trigger level decode.
    reg  [CW-1:0] trigLvl;
    always @* begin
        case (trig_ff) // R15
            2'b00:   trigLvl = `TRIG_LVL0;
            2'b01:   trigLvl = `TRIG_LVL1;
            2'b10:   trigLvl = `TRIG_LVL2;
            default: trigLvl = `TRIG_LVL3;
        endcase
    end

    // Raw pending conditions for each source.
    wire lineP = |lstat_ff[4:1]; // R4
    wire rxP   = fifoEn_ff ? (rxCnt_ff >= trigLvl)
                           : lstat_ff[0]; // R5
    wire toP   = fifoEn_ff & (rxCnt_ff != {CW{1'b0}})
                 & (tmo_ff >= TIMEOUT_CYC[TW-1:0]); // R6
    wire modP  = |mstat_ff; // R8

    // Priority encode of enabled pending sources.
    reg [3:0] liveId;
    always @* begin
        if (ienable_ff[`IE_LINE] & lineP) begin // R1
            liveId = `ID_LINE;
        end else if (ienable_ff[`IE_RXDATA] & toP) begin
            liveId = `ID_TIMEOUT; // R9
        end else if (ienable_ff[`IE_RXDATA] & rxP) begin
            liveId = `ID_RXDATA;
        end else if (ienable_ff[`IE_TXEMPTY] & thre_ff) begin
            liveId = `ID_TXEMPTY; // R7
        end else if (ienable_ff[`IE_MODEM] & modP) begin
            liveId = `ID_MODEM;
        end else begin
            liveId = `ID_NONE; // R17
        end
    end

    // Identification seen by software; frozen during a read.
    wire [3:0] shownId = freeze_ff ? frozen_ff : liveId; // R2
    wire [7:0] identRd = {{2{fifoEn_ff}}, 2'b00, shownId}; // R10 R3

    wire rdIdent = rdAcc & (paddr == `OFS_IDENT);
    wire rdRxBuf = rdAcc & (paddr == `OFS_RXBUF);
    wire wrRxPsh = wrAcc & (paddr == `OFS_RXPUSH);
    wire wrTxPsh = wrAcc & (paddr == `OFS_TXPUSH);
    wire wrTxPop = wrAcc & (paddr == `OFS_TXPOP);
    wire wrFc    = wrAcc & (paddr == `OFS_IDENT); // R11
    wire fcOn    = wrFc & wd[`FC_ENABLE];

    // Read data mux; unmapped addresses read zero with an error.
    reg [7:0] rdByte;
    reg       rdHit;
    always @* begin
        rdHit = 1'b1;
        case (paddr)
            `OFS_RXBUF:   rdByte = 8'h00;
            `OFS_IENABLE: rdByte = {4'h0, ienable_ff}; // R16
            `OFS_IDENT:   rdByte = identRd;
            `OFS_MCTRL:   rdByte = {3'b000, mctrl_ff};
            `OFS_LSTAT:   rdByte = {2'b00, lstat_ff};
            `OFS_MSTAT:   rdByte = {modemLvl, mstat_ff};
            `OFS_STATUS:  rdByte = {fifoEn_ff, pinMode_ff, 1'b0, rxCnt_ff};
            `OFS_RXPUSH:  rdByte = 8'h00;
            `OFS_TXPUSH:  rdByte = 8'h00;
            `OFS_TXPOP:   rdByte = {3'b000, txCnt_ff};
            default: begin
                rdByte = 8'h00;
                rdHit  = 1'b0;
            end
        endcase
    end

    // APB slave: one wait state, answer in the second access cycle.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= (psel & penable & ~pready & ~pwrite)
                       ? {24'h000000, rdByte} : 32'h00000000;
            pslverr <= psel & penable & ~pready & ~rdHit;
        end
    end

    // Identification freeze: latched in the access, released after.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            freeze_ff <= 1'b0;
            frozen_ff <= `ID_NONE;
        end else begin
            freeze_ff <= psel & penable & ~pwrite & ~pready
                         & (paddr == `OFS_IDENT); // R2
            if (!freeze_ff) begin
                frozen_ff <= liveId;
            end
        end
    end

    // Control registers: enables, modem control, queue control.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ienable_ff <= `RST_IENABLE;
            mctrl_ff   <= `RST_MCTRL;
            fifoEn_ff  <= 1'b0;
            pinMode_ff <= 1'b0;
            trig_ff    <= 2'b00;
        end else begin
            if (wrAcc && paddr == `OFS_IENABLE) begin
                ienable_ff <= wd[3:0]; // R16
            end
            if (wrMc) begin
                mctrl_ff <= wd[4:0]; // R18
            end
            if (wrFc) begin
                fifoEn_ff <= wd[`FC_ENABLE]; // R12
                if (wd[`FC_ENABLE]) begin
                    pinMode_ff <= wd[`FC_PINMODE]; // R14
                    trig_ff    <= wd[7:6];
                end
            end
        end
    end

    // Queue occupancy counters with push, pop and clear.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rxCnt_ff <= {CW{1'b0}};
            txCnt_ff <= {CW{1'b0}};
        end else begin
            if ((wrFc && !wd[`FC_ENABLE]) || (fcOn && wd[`FC_RXCLR])) begin
                rxCnt_ff <= {CW{1'b0}}; // R13
            end else if (wrRxPsh && rxCnt_ff < DEPTH[CW-1:0]) begin
                rxCnt_ff <= rxCnt_ff + 1'b1;
            end else if (rdRxBuf && rxCnt_ff != {CW{1'b0}}) begin
                rxCnt_ff <= rxCnt_ff - 1'b1;
            end
            if ((wrFc && !wd[`FC_ENABLE]) || (fcOn && wd[`FC_TXCLR])) begin
                txCnt_ff <= {CW{1'b0}}; // R12
            end else if (wrTxPsh && txCnt_ff < DEPTH[CW-1:0]) begin
                txCnt_ff <= txCnt_ff + 1'b1;
            end else if (wrTxPop && txCnt_ff != {CW{1'b0}}) begin
                txCnt_ff <= txCnt_ff - 1'b1;
            end
        end
    end

    // Timeout timer: reset by receive push, buffer read or an empty receive queue, counts while held.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tmo_ff <= {TW{1'b0}};
        end else if (wrRxPsh || rdRxBuf || rxCnt_ff == {CW{1'b0}}) begin
            tmo_ff <= {TW{1'b0}}; // R6
        end else if (tmo_ff < TIMEOUT_CYC[TW-1:0]) begin
            tmo_ff <= tmo_ff + 1'b1;
        end
    end

    // Line status: bit 0 data ready, bits 4:1 errors; set beats clear.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lstat_ff <= 6'h00;
            thre_ff  <= 1'b1;
        end else begin
            if (wrAcc && paddr == `OFS_LSTAT) begin
                lstat_ff <= wd[5:0]; // R21
            end else begin
                if (rdAcc && paddr == `OFS_LSTAT) begin
                    lstat_ff[4:1] <= 4'h0; // R4
                end
                if (wrRxPsh) begin
                    lstat_ff[0] <= 1'b1;
                end else if (rdRxBuf) begin
                    lstat_ff[0] <= 1'b0; // R5
                end
            end
            // Tx empty: pop to empty or pseudo write sets; clears win less.
            if (wrAcc && paddr == `OFS_LSTAT && wd[5]) begin
                thre_ff <= 1'b1; // R21
            end else if (wrTxPop && txCnt_ff == 5'h01) begin
                thre_ff <= 1'b1;
            end else if (wrTxPsh || (rdIdent && shownId == `ID_TXEMPTY)) begin
                thre_ff <= 1'b0; // R7
            end
        end
    end

    // Modem pins pass two flops; deltas set sticky bits over a read.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            modemS1_ff   <= 4'hf;
            modemS2_ff   <= 4'hf;
            modemPrev_ff <= 4'h0;
            mstat_ff     <= 4'h0;
            sinS1_ff     <= 1'b1;
            sinS2_ff     <= 1'b1;
        end else begin
            modemS1_ff   <= {carrierDetectN, ringN, dsrN, ctsN};
            modemS2_ff   <= modemS1_ff;
            sinS1_ff     <= serialIn;
            sinS2_ff     <= sinS1_ff;
            modemPrev_ff <= modemLvl;
            if (wrAcc && paddr == `OFS_MSTAT) begin
                mstat_ff <= wd[3:0] | mstat_ff; // R21
            end else begin
                mstat_ff <= ((rdAcc && paddr == `OFS_MSTAT) ? 4'h0 : mstat_ff)
                    | {modemLvl[3] ^ modemPrev_ff[3],
                       modemPrev_ff[2] & ~modemLvl[2],
                       modemLvl[1:0] ^ modemPrev_ff[1:0]}; // R8
            end
        end
    end

    // Pin and interrupt outputs, all registered.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            serialOut  <= 1'b1;
            rxShiftIn  <= 1'b1;
            dtrN       <= 1'b1;
            rtsN       <= 1'b1;
            out1N      <= 1'b1;
            out2N      <= 1'b1;
            irqOut     <= 1'b0;
            rxReadyPin <= 1'b1;
            txReadyPin <= 1'b1;
        end else begin
            serialOut  <= mctrl_ff[`MC_LOOP] ? 1'b1 : txShiftOut; // R19
            rxShiftIn  <= mctrl_ff[`MC_LOOP] ? txShiftOut : sinS2_ff;
            dtrN       <= mctrl_ff[`MC_LOOP] | ~mctrl_ff[0]; // R18
            rtsN       <= mctrl_ff[`MC_LOOP] | ~mctrl_ff[1];
            out1N      <= mctrl_ff[`MC_LOOP] | ~mctrl_ff[2];
            out2N      <= mctrl_ff[`MC_LOOP] | ~mctrl_ff[3];
            irqOut     <= (liveId != `ID_NONE); // R23
            rxReadyPin <= (fifoEn_ff && pinMode_ff)
                          ? ~(rxP | toP) : ~lstat_ff[0];
            txReadyPin <= (fifoEn_ff && pinMode_ff)
                          ? (txCnt_ff == DEPTH[CW-1:0]) : ~thre_ff;
        end
    end

endmodule

// File: hdl/uart_intr_ctrl_regs.vh
// Register offsets, field positions, reset values and timing counts
// for the serial controller interrupt, queue and modem control block.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef UART_INTR_CTRL_REGS_VH
`define UART_INTR_CTRL_REGS_VH

// Byte addresses on the register bus.
`define OFS_RXBUF      8'h00
`define OFS_IENABLE    8'h04
`define OFS_IDENT      8'h08
`define OFS_MCTRL      8'h10
`define OFS_LSTAT      8'h14
`define OFS_MSTAT      8'h18
`define OFS_RXPUSH     8'h20
`define OFS_TXPUSH     8'h24
`define OFS_TXPOP      8'h28
`define OFS_STATUS     8'h2c

// Field positions.
`define IE_RXDATA      0
`define IE_TXEMPTY     1
`define IE_LINE        2
`define IE_MODEM       3
`define FC_ENABLE      0
`define FC_RXCLR       1
`define FC_TXCLR       2
`define FC_PINMODE     3
`define MC_LOOP        4

// Identification codes, bits 3..0.
`define ID_NONE        4'h1
`define ID_LINE        4'h6
`define ID_RXDATA      4'h4
`define ID_TIMEOUT     4'hc
`define ID_TXEMPTY     4'h2
`define ID_MODEM       4'h0

// Trigger levels in bytes.
`define TRIG_LVL0      5'h01
`define TRIG_LVL1      5'h04
`define TRIG_LVL2      5'h08
`define TRIG_LVL3      5'h0e

// Reset values.
`define RST_IENABLE    4'h0
`define RST_MCTRL      5'h00

// Character time in ns and the timeout length in character times.
`define CHAR_TIME_NS   1000000
`define TIMEOUT_CHARS  4
`define CLK_PERIOD_NS  100

`endif

// File: tb/modem_model.sv
// Modem and terminal model driving the line and modem inputs.
// Assumes the bench sets wanted levels just after a clock edge.
`timescale 1ns/1ps
module modem_model (
    input  logic       mclk,
    input  logic       rstn,
    input  logic [4:0] want,
    output logic       serialIn,
    output logic       ctsN,
    output logic       dsrN,
    output logic       ringN,
    output logic       carrierDetectN
);
    // Pins follow the request one edge later; with want[4] set the line
    // carries a pattern that changes every cycle, else it marks.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {ctsN, dsrN, ringN, carrierDetectN} <= 4'hf;
            serialIn <= 1'b1;
        end else begin
            {ctsN, dsrN, ringN, carrierDetectN} <= want[3:0];
            serialIn <= want[4] ? ~serialIn : 1'b1;
        end
    end
endmodule

// File: tb/test_uart_intr_ctrl.sv
// Self-checking bench for the interrupt and modem control block.
// Assumes the register header, the checker bind and the modem model.
`timescale 1ns/1ps
`include "uart_intr_ctrl_regs.vh"
module test_uart_intr_ctrl;
    logic        mclk, rstn, psel, penable, pwrite, txShiftOut;
    logic        pready, pslverr, serialIn, ctsN, dsrN, ringN;
    logic        carrierDetectN, serialOut, rxShiftIn, dtrN, rtsN;
    logic        out1N, out2N, irqOut, rxReadyPin, txReadyPin, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  want;
    int          mismatches, cmp_count;
    uart_intr_ctrl #(.TIMEOUT_CYC(20)) uut (
        .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serialIn(serialIn),
        .txShiftOut(txShiftOut), .ctsN(ctsN), .dsrN(dsrN), .ringN(ringN),
        .carrierDetectN(carrierDetectN), .serialOut(serialOut),
        .rxShiftIn(rxShiftIn), .dtrN(dtrN), .rtsN(rtsN), .out1N(out1N),
        .out2N(out2N), .irqOut(irqOut), .rxReadyPin(rxReadyPin),
        .txReadyPin(txReadyPin));
    modem_model far (.mclk(mclk), .rstn(rstn), .want(want),
        .serialIn(serialIn), .ctsN(ctsN), .dsrN(dsrN), .ringN(ringN),
        .carrierDetectN(carrierDetectN));
    // Clock of 100 ns period.
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;
    task end_sim;
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One APB transfer; the request holds until pready is sampled high or 20 access cycles pass.
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", {31'h0, pready}, 32'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task rdChk(input logic [7:0] a, input logic [31:0] e, input string s);
        xfer(a, 1'b0, 32'h0);
        chk(s, rd, e);
    endtask
    task testReset;
        rdChk(`OFS_IENABLE, 32'h0, "enable reset");
        rdChk(`OFS_IDENT, 32'h1, "ident reset");
        chk("irq reset", {31'h0, irqOut}, 32'h0);
        chk("ready pins", {30'h0, rxReadyPin, txReadyPin}, 32'h2);
        xfer(8'hfc, 1'b0, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
    endtask
    task testPriority;
        wr(`OFS_IENABLE, 32'h0f);
        wr(`OFS_LSTAT, 32'h22);
        wr(`OFS_MSTAT, 32'h01);
        wr(`OFS_RXPUSH, 32'h0);
        rdChk(`OFS_IDENT, 32'h06, "ident line");
        chk("irq set", {31'h0, irqOut}, 32'h1);
        xfer(`OFS_LSTAT, 1'b0, 32'h0);
        rdChk(`OFS_IDENT, 32'h04, "ident rx");
        xfer(`OFS_RXBUF, 1'b0, 32'h0);
        rdChk(`OFS_IDENT, 32'h02, "ident tx");
        rdChk(`OFS_IDENT, 32'h00, "ident modem");
        xfer(`OFS_MSTAT, 1'b0, 32'h0);
        rdChk(`OFS_IDENT, 32'h01, "ident none");
        chk("irq clear", {31'h0, irqOut}, 32'h0);
    endtask
    task testTxEmpty;
        wr(`OFS_IENABLE, 32'h02);
        wr(`OFS_LSTAT, 32'h20);
        wr(`OFS_TXPUSH, 32'h41);
        rdChk(`OFS_IDENT, 32'h01, "ident pushed");
        wr(`OFS_LSTAT, 32'h20);
        rdChk(`OFS_IDENT, 32'h02, "ident forced");
        wr(`OFS_TXPOP, 32'h0);
        wr(`OFS_IENABLE, 32'h00);
        rdChk(`OFS_IDENT, 32'h01, "ident masked");
        chk("irq masked", {31'h0, irqOut}, 32'h0);
        wr(`OFS_IENABLE, 32'h02);
        rdChk(`OFS_IDENT, 32'h02, "ident popped");
    endtask
    task testQueue;
        int k, i;
        int lvl [4] = '{1, 4, 8, 14};
        wr(`OFS_IENABLE, 32'h01);
        for (k = 0; k < 4; k++) begin
            wr(`OFS_IDENT, {24'h0, k[1:0], 6'h03});
            for (i = 1; i < lvl[k]; i++) wr(`OFS_RXPUSH, 32'h0);
            rdChk(`OFS_IDENT, 32'hc1, "below trigger");
            wr(`OFS_RXPUSH, 32'h0);
            rdChk(`OFS_IDENT, 32'hc4, "at trigger");
            chk("rx ready pin", {31'h0, rxReadyPin}, 32'h0);
        end
        wr(`OFS_IDENT, 32'h83);
        rdChk(`OFS_STATUS, 32'h80, "rx cleared");
        wr(`OFS_RXPUSH, 32'h0);
        repeat (40) @(posedge mclk);
        rdChk(`OFS_IDENT, 32'hcc, "timeout");
        xfer(`OFS_RXBUF, 1'b0, 32'h0);
        rdChk(`OFS_IDENT, 32'hc1, "timeout gone");
        wr(`OFS_RXPUSH, 32'h0);
        wr(`OFS_IDENT, 32'h00);
        rdChk(`OFS_STATUS, 32'h00, "queues emptied");
        wr(`OFS_IDENT, 32'h08);
        rdChk(`OFS_STATUS, 32'h00, "pin mode held");
        wr(`OFS_IDENT, 32'h09);
        rdChk(`OFS_STATUS, 32'hc0, "pin mode set");
        wr(`OFS_TXPUSH, 32'h0);
        rdChk(`OFS_TXPOP, 32'h01, "tx count");
        wr(`OFS_IDENT, 32'h05);
        rdChk(`OFS_TXPOP, 32'h00, "tx cleared");
        wr(`OFS_IDENT, 32'h00);
        wr(`OFS_IENABLE, 32'h00);
    endtask
    task testModem;
        int i;
        for (i = 0; i < 4; i++) begin
            wr(`OFS_MCTRL, 32'h1 << i);
            rdChk(`OFS_MCTRL, 32'h1 << i, "control");
            chk("pins", {28'h0, out2N, out1N, rtsN, dtrN},
                {28'h0, ~(4'h1 << i)});
        end
        wr(`OFS_IENABLE, 32'h08);
        wr(`OFS_MCTRL, 32'h00);
        xfer(`OFS_MSTAT, 1'b0, 32'h0);
        want <= 5'h07;
        repeat (4) @(posedge mclk);
        rdChk(`OFS_IDENT, 32'h00, "ident pin");
        rdChk(`OFS_MSTAT, 32'h11, "status pin");
        want <= 5'h1f;
        repeat (4) @(posedge mclk);
        xfer(`OFS_MSTAT, 1'b0, 32'h0);
        wr(`OFS_MCTRL, 32'h10);
        want <= 5'h10;
        xfer(`OFS_MSTAT, 1'b0, 32'h0);
        wr(`OFS_MCTRL, 32'h11);
        rdChk(`OFS_IDENT, 32'h00, "ident loop");
        rdChk(`OFS_MSTAT, 32'h22, "status loop");
        chk("loop pins", {serialOut, out2N, out1N, rtsN, dtrN}, 5'h1f);
        repeat (8) @(posedge mclk) txShiftOut <= ~txShiftOut;
        want <= 5'h0f;
        wr(`OFS_MCTRL, 32'h00);
        xfer(`OFS_MSTAT, 1'b0, 32'h0);
        repeat (4) @(posedge mclk) txShiftOut <= ~txShiftOut;
        wr(`OFS_IENABLE, 32'h00);
    endtask
    // Main sequence: reset for twelve cycles, then every scenario.
    initial begin
        {psel, penable, pwrite, txShiftOut} = 4'h1;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = 5'h0f;
        rstn = 1'b0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        testReset;
        testPriority;
        testTxEmpty;
        testQueue;
        testModem;
        end_sim;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (10000) @(posedge mclk);
        mismatches++;
        end_sim;
    end
endmodule

// File: tb/uart_intr_ctrl_checker.sv
// Port checker for the interrupt and modem control block.
// Assumes the shared register header and one clock with async reset.
`timescale 1ns/1ps
`include "uart_intr_ctrl_regs.vh"
module uart_intr_ctrl_checker (
    input wire        mclk,
    input wire        rstn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        txShiftOut,
    input wire        serialIn,
    input wire        serialOut,
    input wire        rxShiftIn,
    input wire        dtrN,
    input wire        rtsN,
    input wire        out1N,
    input wire        out2N,
    input wire        irqOut
);
    logic       acc;
    logic       rdAcc;
    logic       wrMc;
    logic [4:0] mc_ff;
    logic [3:0] ie_ff;
    logic       fen_ff;
    // A transfer completes where pready is seen inside an access.
    assign acc   = psel && penable && pready;
    assign rdAcc = acc && !pwrite;
    assign wrMc  = acc && pwrite && paddr == `OFS_MCTRL;
    // Shadows of control values, updated when a write takes.
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mc_ff  <= 5'h00;
            ie_ff  <= 4'h0;
            fen_ff <= 1'b0;
        end else if (acc && pwrite) begin
            if (paddr == `OFS_MCTRL) mc_ff <= pwdata[4:0];
            if (paddr == `OFS_IENABLE) ie_ff <= pwdata[3:0];
            if (paddr == `OFS_IDENT) fen_ff <= pwdata[0];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Bus timing, pins, loopback, read-back formats and interrupt masking.
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    pin_drive_a: assert property (wrMc |-> ##2
        {out2N, out1N, rtsN, dtrN} == (mc_ff[4] ? 4'hf : ~mc_ff[3:0]))
        else $error("modem pins wrong");
    loop_mark_a: assert property (mc_ff[4] && $past(mc_ff[4], 2)
        |-> serialOut) else $error("serial out not marking");
    loop_echo_a: assert property (mc_ff[4] && $past(mc_ff[4], 2)
        |-> rxShiftIn == $past(txShiftOut)) else $error("no loop echo");
    line_pass_a: assert property (!mc_ff[4] && !$past(mc_ff[4], 2)
        |-> rxShiftIn == $past(serialIn, 3))
        else $error("serial in not passed");
    tx_pass_a: assert property (!mc_ff[4] && !$past(mc_ff[4], 2)
        |-> serialOut == $past(txShiftOut))
        else $error("serial out not passed");
    ident_hi_a: assert property (rdAcc && paddr == `OFS_IDENT
        |-> prdata[31:4] == {24'h0, fen_ff, fen_ff, 2'b00})
        else $error("ident upper bits wrong");
    ie_read_a: assert property (rdAcc && paddr == `OFS_IENABLE
        |-> prdata == {28'h0, ie_ff}) else $error("enable readback");
    mc_read_a: assert property (rdAcc && paddr == `OFS_MCTRL
        |-> prdata == {27'h0, mc_ff}) else $error("control readback");
    irq_off_a: assert property (ie_ff == 4'h0
        && $past(ie_ff == 4'h0, 2) |-> !irqOut) else $error("irq leak");
endmodule
bind uart_intr_ctrl uart_intr_ctrl_checker chk (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txShiftOut(txShiftOut),
    .serialIn(serialIn),
    .serialOut(serialOut), .rxShiftIn(rxShiftIn), .dtrN(dtrN),
    .rtsN(rtsN), .out1N(out1N), .out2N(out2N), .irqOut(irqOut));
